/* dcerr_params.svh */
// Constants for the DMA channel controller error register bank
// Assumes 32-bit classic Wishbone register access, byte addresses
`ifndef DCERR_PARAMS_SVH
`define DCERR_PARAMS_SVH

`define DCERR_OFS_STATUS      8'h00
`define DCERR_OFS_CLEAR       8'h04
`define DCERR_OFS_THRESH      8'h08
`define DCERR_OFS_QSTAT_BASE  8'h10
`define DCERR_BIT_CCLIMIT     16
`define DCERR_NUM_QUEUES      6
`define DCERR_CC_MAX          63
`define DCERR_CNT_W           7
`define DCERR_QCNT_W          5
`define DCERR_THRESH_RESET    32'h0000_1010

`endif

/* dcerr_pkg.sv */
// Types for the DMA channel controller error register bank
// Assumes dcerr_params.svh is available on the include path
package dcerr_pkg;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } dcerr_wb_req_t;

    typedef struct packed {
        logic [4:0] peak;
        logic       exceeded;
    } dcerr_qstat_t;
endpackage : dcerr_pkg

/* dcerr_queue_mon.sv */
// Per-queue watermark monitor: threshold compare, peak level, exceeded flag
// Assumes queue level comes from logic on the same clock
`timescale 1ns/1ps
`include "dcerr_params.svh"
module dcerr_queue_mon #(
    parameter int QW = `DCERR_QCNT_W
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic [QW-1:0]         level_i,
    input  wire logic [QW-1:0]         thresh_i,
    input  wire logic                  clr_i,
    output logic                       thr_o,
    output dcerr_pkg::dcerr_qstat_t    stat_o
);
    assign thr_o = (level_i >= thresh_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_o <= '0;
        end else if (thr_o) begin
            stat_o.exceeded <= 1'b1;
            stat_o.peak     <= (clr_i || level_i > stat_o.peak) ? level_i : stat_o.peak;
        end else if (clr_i) begin
            stat_o <= '0;
        end else if (level_i > stat_o.peak) begin
            stat_o.peak <= level_i;
        end
    end

    chk_peak_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && !clr_i && !$past(clr_i) |-> stat_o.peak >= $past(level_i))
        else $error("peak below previous level");
endmodule : dcerr_queue_mon

/* dcerr_regs.sv */
// Error status / error clear register bank of a DMA channel controller
// Assumes one clock, synchronous reset, classic Wishbone master
`timescale 1ns/1ps
`include "dcerr_params.svh"
module dcerr_regs #(
    parameter int NQ = `DCERR_NUM_QUEUES,
    parameter int CW = `DCERR_CNT_W,
    parameter int QW = `DCERR_QCNT_W
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         wb_err_o,
    input  wire logic                    req_issue_i,
    input  wire logic                    req_intr_en_i,
    input  wire logic                    req_chain_en_i,
    input  wire logic                    code_return_i,
    input  wire logic [NQ*QW-1:0]        queue_level_i,
    input  wire logic                    missed_any_i,
    output logic                         error_irq_o,
    output logic [CW-1:0]                outstanding_o
);
    dcerr_pkg::dcerr_wb_req_t  req;
    dcerr_pkg::dcerr_qstat_t   qstat [NQ];
    logic [NQ-1:0]             thr;
    logic [NQ-1:0]             qflag;
    logic                      ccflag;
    logic [31:0]               thresh;
    logic                      acc;
    logic                      wr;
    logic [31:0]               clr_word;
    logic                      cc_count_up;
    logic                      cc_over;
    logic                      any_err;
    logic                      any_err_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    function automatic logic [31:0] lanes(input logic [31:0] d, input logic [3:0] s);
        return d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : lanes

    assign req      = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                        adr: wb_adr_i, dat: wb_dat_i};
    assign acc      = req.cyc && req.stb && !wb_ack_o && !wb_err_o;
    assign wr       = acc && req.we;
    assign clr_word = (wr && hit(req.adr, `DCERR_OFS_CLEAR)) ? lanes(req.dat, req.sel) : '0;

    function automatic logic mapped(input logic [7:0] a);
        logic ok;
        ok = hit(a, `DCERR_OFS_STATUS) || hit(a, `DCERR_OFS_CLEAR)
             || hit(a, `DCERR_OFS_THRESH);
        for (int i = 0; i < `DCERR_NUM_QUEUES; i++) begin
            ok = ok || hit(a, 8'(`DCERR_OFS_QSTAT_BASE + 4 * i));
        end
        return ok;
    endfunction : mapped

    // Outstanding completion-code count
    assign cc_count_up = req_issue_i && (req_intr_en_i || req_chain_en_i);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            outstanding_o <= '0;
        end else if (cc_count_up && !code_return_i) begin
            outstanding_o <= (outstanding_o == '1) ? outstanding_o : outstanding_o + CW'(1);
        end else if (!cc_count_up && code_return_i && outstanding_o != '0) begin
            outstanding_o <= outstanding_o - CW'(1);
        end
    end
    assign cc_over = outstanding_o > CW'(`DCERR_CC_MAX);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ccflag <= 1'b0;
        end else if (cc_over) begin
            ccflag <= 1'b1;
        end else if (clr_word[`DCERR_BIT_CCLIMIT]) begin
            ccflag <= 1'b0;
        end
    end

    // Queue monitors and status flags
    genvar g;
    generate
        for (g = 0; g < NQ; g++) begin : g_queue
            dcerr_queue_mon #(.QW(QW)) u_mon (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .level_i  (queue_level_i[g*QW +: QW]),
                .thresh_i (thresh[g*8 % 32 +: QW]),
                .clr_i    (clr_word[g]),
                .thr_o    (thr[g]),
                .stat_o   (qstat[g])
            );
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    qflag[g] <= 1'b0;
                end else if (thr[g]) begin
                    qflag[g] <= 1'b1;
                end else if (clr_word[g]) begin
                    qflag[g] <= 1'b0;
                end
            end
            chk_q_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
                !thr[g] && !qflag[g] |=> !qflag[g])
                else $error("queue flag set without cause");
        end
    endgenerate

    // Threshold configuration, four queues per word; queues 4..5 wrap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thresh <= `DCERR_THRESH_RESET;
        end else if (wr && hit(req.adr, `DCERR_OFS_THRESH)) begin
            thresh <= (thresh & ~lanes('1, req.sel)) | lanes(req.dat, req.sel);
        end
    end

    // Error interrupt: one pulse per none-to-some transition
    assign any_err = ccflag || (|qflag) || missed_any_i;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            any_err_q <= 1'b0;
        end else begin
            any_err_q <= any_err;
        end
    end
    assign error_irq_o = any_err && !any_err_q;

    // Bus answer: one-cycle ack, err on unmapped address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= acc && mapped(req.adr);
            wb_err_o <= acc && !mapped(req.adr);
            wb_dat_o <= '0;
            if (acc && !req.we) begin
                if (hit(req.adr, `DCERR_OFS_STATUS)) begin
                    wb_dat_o <= 32'((32'(ccflag) << `DCERR_BIT_CCLIMIT) | 32'(qflag));
                end else if (hit(req.adr, `DCERR_OFS_THRESH)) begin
                    wb_dat_o <= thresh;
                end else begin
                    for (int i = 0; i < NQ; i++) begin
                        if (hit(req.adr, 8'(`DCERR_OFS_QSTAT_BASE + 4 * i))) begin
                            wb_dat_o <= {23'h00_0000, qstat[i].exceeded,
                                         3'h0, qstat[i].peak};
                        end
                    end
                end
            end
        end
    end

    // Checks beside the logic they guard
    chk_cc_set: assert property (@(posedge clk_i) disable iff (rst_i)
        cc_over |=> ccflag)
        else $error("limit flag not set");
    chk_cc_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !cc_over && !ccflag |=> !ccflag)
        else $error("limit flag set without cause");
    chk_q_set: assert property (@(posedge clk_i) disable iff (rst_i)
        thr[0] |=> qflag[0] && qstat[0].exceeded)
        else $error("queue flag not set");
    chk_hold_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ccflag && !clr_word[`DCERR_BIT_CCLIMIT] |=> ccflag)
        else $error("limit flag dropped");
    chk_zero_write: assert property (@(posedge clk_i) disable iff (rst_i)
        qflag[1] && !clr_word[1] |=> qflag[1])
        else $error("queue flag dropped");
    chk_cc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        clr_word[`DCERR_BIT_CCLIMIT] && !cc_over |=> !ccflag)
        else $error("limit flag not cleared");
    chk_q_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        clr_word[2] && !thr[2] |=> !qflag[2] && qstat[2].peak == '0)
        else $error("queue clear failed");
    chk_irq_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        error_irq_o |=> !error_irq_o)
        else $error("interrupt longer than a pulse");
    chk_irq_first: assert property (@(posedge clk_i) disable iff (rst_i)
        !any_err && (cc_over || (|thr)) |=> error_irq_o)
        else $error("no interrupt on first error");
    chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        thr[3] && clr_word[3] |=> qflag[3])
        else $error("set lost to clear");
    chk_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    chk_clear_reads: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && !req.we && hit(req.adr, `DCERR_OFS_CLEAR) |=> wb_ack_o && wb_dat_o == '0)
        else $error("clear register read not zero");
    chk_thresh_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr && hit(req.adr, `DCERR_OFS_THRESH)) |=> thresh == $past(thresh))
        else $error("threshold changed without write");

    cov_cc_limit: cover property (@(posedge clk_i) cc_over ##1 ccflag);
    cov_q_clear: cover property (@(posedge clk_i) qflag[0] ##1 clr_word[0]);
    cov_irq: cover property (@(posedge clk_i) error_irq_o);
    cov_set_wins: cover property (@(posedge clk_i) thr[3] && clr_word[3]);
    cov_cc_persist: cover property (@(posedge clk_i) cc_over && clr_word[`DCERR_BIT_CCLIMIT]);
endmodule : dcerr_regs

/* dcerr_regs_test.sv */
// Self-checking bench for the error status / clear register bank
// Assumes dcerr_params.svh on the include path; bench drives every port
`timescale 1ns/1ps
`include "dcerr_params.svh"
module dcerr_regs_test;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [3:0]  wb_sel_i;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        wb_ack_o, wb_err_o, error_irq_o, er;
    logic        req_issue_i, req_intr_en_i, req_chain_en_i, code_return_i, missed_any_i;
    logic [29:0] queue_level_i;
    logic [6:0]  outstanding_o;
    int          mismatches, checked, cycles, irqs, irq_base;

    dcerr_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .req_issue_i(req_issue_i), .req_intr_en_i(req_intr_en_i),
        .req_chain_en_i(req_chain_en_i), .code_return_i(code_return_i),
        .queue_level_i(queue_level_i), .missed_any_i(missed_any_i),
        .error_irq_o(error_irq_o), .outstanding_o(outstanding_o));

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (error_irq_o === 1'b1) irqs <= irqs + 1;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    task wrap_up();
        if (mismatches == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // One classic cycle; held until ack or err sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
        if (n >= 50) check("wb answer", 32'h0000_0001, 32'h0000_0000);
    endtask : wb

    task issue(input logic ie, input logic ce);
        @(posedge clk_i);
        req_issue_i <= 1'b1; req_intr_en_i <= ie; req_chain_en_i <= ce;
        @(posedge clk_i);
        req_issue_i <= 1'b0;
    endtask : issue

    initial begin
        clk_i = 0; rst_i = 1; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; wb_sel_i = 4'hF;
        wb_adr_i = 8'h00; wb_dat_i = 32'h0000_0000; req_issue_i = 0; req_intr_en_i = 0;
        req_chain_en_i = 0; code_return_i = 0; missed_any_i = 0; queue_level_i = '0;
        mismatches = 0; checked = 0; cycles = 0; irqs = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        check("count reset", 32'h0000_0000, 32'(outstanding_o));
        wb(0, `DCERR_OFS_THRESH, 0); check("thresh reset", `DCERR_THRESH_RESET, rd);
        wb(0, 8'h40, 0); check("unmapped err", 32'h0000_0001, 32'(er));
        wb(1, `DCERR_OFS_THRESH, 32'h0A0A_0A0A);
        wb(1, `DCERR_OFS_CLEAR, 32'h0001_003F);
        wb(0, `DCERR_OFS_CLEAR, 0); check("clear reads", 32'h0000_0000, rd);
        irq_base = irqs;
        for (int n = 0; n < `DCERR_NUM_QUEUES; n++) begin
            queue_level_i[5*n +: 5] <= 5'h09;
            repeat (3) @(posedge clk_i);
            wb(0, `DCERR_OFS_STATUS, 0); check("below thresh", 32'h0000_0000, rd);
            queue_level_i[5*n +: 5] <= 5'h0A;
            repeat (3) @(posedge clk_i);
            queue_level_i[5*n +: 5] <= 5'h00;
            repeat (3) @(posedge clk_i);
            wb(0, `DCERR_OFS_STATUS, 0); check("q flag", 32'h1 << n, rd);
            wb(0, `DCERR_OFS_STATUS, 0); check("q flag held", 32'h1 << n, rd);
            wb(1, `DCERR_OFS_CLEAR, 32'h0001_0000 | ~(32'h1 << n));
            wb(0, `DCERR_OFS_STATUS, 0); check("zero clear", 32'h1 << n, rd);
            wb(0, `DCERR_OFS_QSTAT_BASE + 8'(4 * n), 0);
            check("qstat set", 32'h0000_010A, rd);
            wb(1, `DCERR_OFS_CLEAR, 32'h1 << n);
            wb(0, `DCERR_OFS_STATUS, 0); check("q cleared", 32'h0000_0000, rd);
            wb(0, `DCERR_OFS_QSTAT_BASE + 8'(4 * n), 0);
            check("qstat clear", 32'h0000_0000, rd);
        end
        missed_any_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        queue_level_i[15 +: 5] <= 5'h0A;
        repeat (3) @(posedge clk_i);
        wb(1, `DCERR_OFS_CLEAR, 32'h0000_0008);
        wb(0, `DCERR_OFS_STATUS, 0); check("set wins", 32'h0000_0008, rd);
        wb(0, `DCERR_OFS_QSTAT_BASE + 8'h0C, 0);
        check("qstat kept", 32'h0000_010A, rd);
        queue_level_i[15 +: 5] <= 5'h00;
        missed_any_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        wb(1, `DCERR_OFS_CLEAR, 32'h0000_0008);
        wb(0, `DCERR_OFS_STATUS, 0); check("q3 cleared", 32'h0000_0000, rd);
        check("irq while missed", 32'h0000_0007, 32'(irqs - irq_base));
        issue(0, 0);
        @(posedge clk_i);
        check("no report req", 32'h0000_0000, 32'(outstanding_o));
        for (int i = 0; i < `DCERR_CC_MAX; i++) issue(i[0], ~i[0]);
        repeat (2) @(posedge clk_i);
        check("count max", `DCERR_CC_MAX, 32'(outstanding_o));
        wb(0, `DCERR_OFS_STATUS, 0); check("limit not yet", 32'h0000_0000, rd);
        issue(1, 1);
        repeat (2) @(posedge clk_i);
        wb(0, `DCERR_OFS_STATUS, 0); check("limit flag", 32'h0001_0000, rd);
        wb(1, `DCERR_OFS_CLEAR, 32'h0001_0000);
        wb(0, `DCERR_OFS_STATUS, 0); check("limit persists", 32'h0001_0000, rd);
        @(posedge clk_i); code_return_i <= 1'b1;
        @(posedge clk_i); code_return_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        wb(1, `DCERR_OFS_CLEAR, 32'h0001_0000);
        wb(0, `DCERR_OFS_STATUS, 0); check("limit cleared", 32'h0000_0000, rd);
        check("irq pulses", 32'h0000_0008, 32'(irqs - irq_base));
        wrap_up();
    end
endmodule : dcerr_regs_test
